// *** src/rail_pin_pkg.sv ***
package rail_pin_pkg;
  // counts and widths of the pin-control block
  localparam int NUM_CTL = 6;
  localparam int NUM_RAIL = 16;
  localparam int NUM_GEN = 4;
  localparam int NUM_IRQ = 8;
  localparam int VSEL_W = 8;
  // the two inputs that can serve as sleep requests (zero based)
  localparam int SLEEP_A_IDX = 2;
  localparam int SLEEP_B_IDX = 5;
  // reset values
  localparam logic [NUM_RAIL-1:0] RAIL_EN_RST = 16'h0000;
  localparam logic [NUM_IRQ-1:0] IRQ_RST = 8'h00;
  // general output source codes
  localparam logic GEN_SRC_PGOOD = 1'b0;
  localparam logic GEN_SRC_REGBIT = 1'b1;
  // rail power state
  typedef enum logic [2:0] {
    RAIL_OFF = 3'b001,
    RAIL_NORMAL = 3'b010,
    RAIL_SLEEP = 3'b100
  } rail_state_e;
endpackage : rail_pin_pkg

// *** src/rail_enable_pin_control.sv ***
`timescale 1ns/1ps
module rail_enable_pin_control (
  input wire logic clk,
  input wire logic rst,
  // control pins
  input wire logic rail_enable_in_1,
  input wire logic rail_enable_in_2,
  input wire logic rail_enable_or_sleep_in_a,
  input wire logic rail_enable_in_4,
  input wire logic rail_enable_in_5,
  input wire logic rail_enable_or_sleep_in_b,
  // configuration
  input wire logic [rail_pin_pkg::NUM_RAIL-1:0] ctl_group [rail_pin_pkg::NUM_CTL],
  input wire logic sleep_mode_a,
  input wire logic sleep_mode_b,
  input wire logic [rail_pin_pkg::NUM_RAIL-1:0] sleep_group_a,
  input wire logic [rail_pin_pkg::NUM_RAIL-1:0] sleep_group_b,
  input wire logic [rail_pin_pkg::VSEL_W-1:0] normal_vsel [rail_pin_pkg::NUM_RAIL],
  input wire logic [rail_pin_pkg::VSEL_W-1:0] sleep_vsel [rail_pin_pkg::NUM_RAIL],
  // general outputs configuration and status
  input wire logic [rail_pin_pkg::NUM_RAIL-1:0] rail_pgood,
  input wire logic [rail_pin_pkg::NUM_RAIL-1:0] gen_pgood_mask [rail_pin_pkg::NUM_GEN],
  input wire logic [rail_pin_pkg::NUM_GEN-1:0] gen_src_sel,
  input wire logic [rail_pin_pkg::NUM_GEN-1:0] gen_reg_bit,
  input wire logic [2:0] gen_push_pull,
  // interrupt causes
  input wire logic [rail_pin_pkg::NUM_IRQ-1:0] irq_set,
  input wire logic [rail_pin_pkg::NUM_IRQ-1:0] irq_clear,
  // rail control
  output logic [rail_pin_pkg::NUM_RAIL-1:0] rail_enable,
  output logic [rail_pin_pkg::NUM_RAIL-1:0] rail_sleep,
  output logic [rail_pin_pkg::VSEL_W-1:0] rail_vsel [rail_pin_pkg::NUM_RAIL],
  // pins, with output enables
  output logic gen_out_1,
  output logic gen_out_1_oe,
  output logic gen_out_2,
  output logic gen_out_2_oe,
  output logic gen_out_3,
  output logic gen_out_3_oe,
  output logic gen_out_opendrain,
  output logic gen_out_opendrain_oe,
  output logic interrupt_out_n,
  output logic interrupt_out_n_oe,
  output logic [rail_pin_pkg::NUM_IRQ-1:0] irq_status
);
  import rail_pin_pkg::*;

  logic [NUM_CTL-1:0] ctl_raw;
  logic [NUM_CTL-1:0] sync1_reg;
  logic [NUM_CTL-1:0] sync2_reg;
  logic [NUM_CTL-1:0] prev_reg;
  logic [NUM_RAIL-1:0] rail_en_next;
  logic [NUM_RAIL-1:0] sleep_next;
  logic [NUM_GEN-1:0] gen_level;
  logic [NUM_GEN-1:0] gen_level_reg;
  logic [3:0] gen_pp;
  rail_state_e rail_state [NUM_RAIL];

  assign ctl_raw = {rail_enable_or_sleep_in_b, rail_enable_in_5, rail_enable_in_4,
                    rail_enable_or_sleep_in_a, rail_enable_in_2, rail_enable_in_1};

  // two-stage synchroniser and edge memory, free running through reset
  // so a level already held at release is never taken for an edge;
  // reset must last three edges for the chain to fill
  always_ff @(posedge clk) begin
    sync1_reg <= ctl_raw;
    sync2_reg <= sync1_reg;
    prev_reg <= sync2_reg;
  end

  // edge-driven enables; sleep-mode inputs do not enable rails
  always_comb begin
    rail_en_next = rail_enable;
    for (int i = 0; i < NUM_CTL; i++) begin
      if (!((i == SLEEP_A_IDX && sleep_mode_a) || (i == SLEEP_B_IDX && sleep_mode_b))) begin
        if (sync2_reg[i] && !prev_reg[i]) begin
          rail_en_next = rail_en_next | ctl_group[i];
        end else if (!sync2_reg[i] && prev_reg[i]) begin
          rail_en_next = rail_en_next & ~ctl_group[i];
        end
      end
    end
  end

  // sleep follows the low level of a sleep-mode input
  always_comb begin
    sleep_next = 16'h0000;
    if (sleep_mode_a && !sync2_reg[SLEEP_A_IDX]) begin
      sleep_next = sleep_next | sleep_group_a;
    end
    if (sleep_mode_b && !sync2_reg[SLEEP_B_IDX]) begin
      sleep_next = sleep_next | sleep_group_b;
    end
  end

  // rail enable and sleep registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rail_enable <= RAIL_EN_RST;
      rail_sleep <= 16'h0000;
    end else begin
      rail_enable <= rail_en_next;
      rail_sleep <= sleep_next & rail_en_next;
    end
  end

  // per-rail state and voltage selection
  for (genvar r = 0; r < NUM_RAIL; r++) begin : g_rail
    always_ff @(posedge clk) begin
      if (rst) begin
        rail_state[r] <= RAIL_OFF;
        rail_vsel[r] <= 8'h00;
      end else begin
        unique case (1'b1)
          !rail_en_next[r]: rail_state[r] <= RAIL_OFF;
          sleep_next[r]: rail_state[r] <= RAIL_SLEEP;
          default: rail_state[r] <= RAIL_NORMAL;
        endcase
        rail_vsel[r] <= (sleep_next[r] && rail_en_next[r]) ? sleep_vsel[r]
                                                           : normal_vsel[r];
      end
    end
  end

  // source choice, made before and apart from the driver type
  always_comb begin
    for (int g = 0; g < NUM_GEN; g++) begin
      if (gen_src_sel[g] == GEN_SRC_REGBIT) begin
        gen_level[g] = gen_reg_bit[g];
      end else begin
        gen_level[g] = &(rail_pgood | ~gen_pgood_mask[g]);
      end
    end
  end

  assign gen_pp = {1'b0, gen_push_pull};

  // driver stage: open-drain drives only low
  always_ff @(posedge clk) begin
    if (rst) begin
      gen_level_reg <= 4'h0;
      gen_out_1 <= 1'b0;
      gen_out_1_oe <= 1'b0;
      gen_out_2 <= 1'b0;
      gen_out_2_oe <= 1'b0;
      gen_out_3 <= 1'b0;
      gen_out_3_oe <= 1'b0;
      gen_out_opendrain <= 1'b0;
      gen_out_opendrain_oe <= 1'b0;
    end else begin
      gen_level_reg <= gen_level;
      gen_out_1 <= gen_level[0];
      gen_out_1_oe <= gen_pp[0] | !gen_level[0];
      gen_out_2 <= gen_level[1];
      gen_out_2_oe <= gen_pp[1] | !gen_level[1];
      gen_out_3 <= gen_level[2];
      gen_out_3_oe <= gen_pp[2] | !gen_level[2];
      gen_out_opendrain <= 1'b0;
      gen_out_opendrain_oe <= !gen_level[3];
    end
  end

  // sticky interrupt causes, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status <= IRQ_RST;
      interrupt_out_n <= 1'b0;
      interrupt_out_n_oe <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_set;
      interrupt_out_n <= 1'b0;
      interrupt_out_n_oe <= |irq_status;
    end
  end

  sequence s_ctl_rise(int i);
    !prev_reg[i] && sync2_reg[i];
  endsequence

  a_enable_on_rise: assert property (@(posedge clk) disable iff (rst)
    (s_ctl_rise(0)) |=> ((rail_enable & ctl_group[0]) == ctl_group[0]) || $changed(ctl_group[0]))
    else $error("group not enabled after input rise");
  a_enable_off_fall: assert property (@(posedge clk) disable iff (rst)
    (prev_reg[1] && !sync2_reg[1]
     && !(sync2_reg[SLEEP_A_IDX] && !prev_reg[SLEEP_A_IDX] && !sleep_mode_a)
     && !(sync2_reg[3] && !prev_reg[3]) && !(sync2_reg[4] && !prev_reg[4])
     && !(sync2_reg[SLEEP_B_IDX] && !prev_reg[SLEEP_B_IDX] && !sleep_mode_b))
    |=> ((rail_enable & $past(ctl_group[1])) == 16'h0000))
    else $error("group not disabled after input fall");
  a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
    (sleep_mode_a && !sync2_reg[SLEEP_A_IDX])
    |=> ((rail_sleep & $past(sleep_group_a & rail_en_next))
         == $past(sleep_group_a & rail_en_next)))
    else $error("sleep request not honoured");
  a_sleep_entry_b: assert property (@(posedge clk) disable iff (rst)
    (sleep_mode_b && !sync2_reg[SLEEP_B_IDX])
    |=> ((rail_sleep & $past(sleep_group_b & rail_en_next))
         == $past(sleep_group_b & rail_en_next)))
    else $error("second sleep request not honoured");
  a_sleep_vsel: assert property (@(posedge clk) disable iff (rst)
    rail_sleep[2] |-> rail_vsel[2] == $past(sleep_vsel[2]))
    else $error("sleeping rail not on sleep voltage");
  a_normal_vsel: assert property (@(posedge clk) disable iff (rst)
    rail_enable[2] && !rail_sleep[2] |-> rail_vsel[2] == $past(normal_vsel[2]))
    else $error("awake rail not on normal voltage");
  a_od_never_high: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> !gen_out_opendrain && gen_out_opendrain_oe == !$past(gen_level[3]))
    else $error("open-drain output driven high or wrong");
  a_pp_drives: assert property (@(posedge clk) disable iff (rst)
    $past(gen_push_pull[0]) && !$past(rst) |-> gen_out_1_oe && gen_out_1 == $past(gen_level[0]))
    else $error("push-pull output not driven");
  a_regbit_src: assert property (@(posedge clk) disable iff (rst)
    $past(gen_src_sel[1]) && !$past(rst) |-> gen_level_reg[1] == $past(gen_reg_bit[1]))
    else $error("register bit source not followed");
  a_src_indep: assert property (@(posedge clk) disable iff (rst)
    gen_out_2_oe && !gen_push_pull[1] ##0 1'b1 |-> !gen_out_2 || $past(gen_push_pull[1]))
    else $error("open-drain output drives high");
  a_irq_line: assert property (@(posedge clk) disable iff (rst)
    (|irq_set) |=> ##1 interrupt_out_n_oe)
    else $error("interrupt line not pulled low");
  a_sync_delay: assert property (@(posedge clk) disable iff (rst)
    sync2_reg == $past(ctl_raw, 2) || $past(rst, 2) || $past(rst))
    else $error("control input not two-stage synchronised");
endmodule : rail_enable_pin_control

// *** test/host_pins.sv ***
`timescale 1ns/1ps
// host side of the six control pins, levels held until changed
module host_pins (
  // pins toward the device
  output logic [5:0] pins
);
  // sleep-capable pins idle high so no sleep is requested
  initial pins = 6'h24;
  // bench calls this just after a falling clock edge
  task set_pin(input int idx, input logic val);
    pins[idx] = val;
  endtask : set_pin
endmodule : host_pins

// *** test/testbench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  import rail_pin_pkg::*;
  logic clk = 0, rst = 1, sm_a = 1, sm_b = 0;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  logic [5:0] pins;
  logic [NUM_RAIL-1:0] grp [NUM_CTL], msk [NUM_GEN], sg_a, sg_b, pg, en, slp;
  logic [VSEL_W-1:0] nv [NUM_RAIL], sv [NUM_RAIL], vsel [NUM_RAIL];
  logic [NUM_GEN-1:0] src = 0, rb = 0;
  logic [2:0] pp = 3'h1;
  logic [NUM_IRQ-1:0] iset = 0, iclr = 0, ist;
  logic [4:0] o, oe, lv;
  // pin level seen on the board, pulled up when released
  always_comb for (int i = 0; i < 5; i++) lv[i] = oe[i] ? o[i] : 1'b1;
  always #5 clk = ~clk;
  host_pins i_host (.pins(pins));
  rail_enable_pin_control i_dut (.clk(clk), .rst(rst),
    .rail_enable_in_1(pins[0]), .rail_enable_in_2(pins[1]),
    .rail_enable_or_sleep_in_a(pins[2]), .rail_enable_in_4(pins[3]),
    .rail_enable_in_5(pins[4]), .rail_enable_or_sleep_in_b(pins[5]),
    .ctl_group(grp), .sleep_mode_a(sm_a), .sleep_mode_b(sm_b),
    .sleep_group_a(sg_a), .sleep_group_b(sg_b), .normal_vsel(nv), .sleep_vsel(sv),
    .rail_pgood(pg), .gen_pgood_mask(msk), .gen_src_sel(src), .gen_reg_bit(rb),
    .gen_push_pull(pp), .irq_set(iset), .irq_clear(iclr), .rail_enable(en),
    .rail_sleep(slp), .rail_vsel(vsel), .gen_out_1(o[0]), .gen_out_1_oe(oe[0]),
    .gen_out_2(o[1]), .gen_out_2_oe(oe[1]), .gen_out_3(o[2]), .gen_out_3_oe(oe[2]),
    .gen_out_opendrain(o[3]), .gen_out_opendrain_oe(oe[3]),
    .interrupt_out_n(o[4]), .interrupt_out_n_oe(oe[4]), .irq_status(ist));
  task wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // hang guard, the whole run needs about 35 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    for (int i = 0; i < NUM_RAIL; i++) begin
      nv[i] = 8'h10 + 8'(i);
      sv[i] = 8'h80 + 8'(i);
    end
    for (int i = 0; i < NUM_CTL; i++) grp[i] = 16'h0003 << (2 * i);
    for (int i = 0; i < NUM_GEN; i++) msk[i] = 16'h0001 << i;
    sg_a = 16'h000c;
    sg_b = 16'h0000;
    pg = 16'h0005;
    wt(3);
    rst = 0;
    // enable pin rises then falls
    i_host.set_pin(0, 1);
    wt(2);
    `CHK("en_sync", 16'h0000, en)
    wt(1);
    `CHK("en_on", 16'h0003, en)
    i_host.set_pin(0, 0);
    wt(3);
    `CHK("en_off", 16'h0000, en)
    // sixth pin as plain enable, second pin enables the sleep group
    i_host.set_pin(5, 0);
    i_host.set_pin(1, 1);
    wt(3);
    i_host.set_pin(5, 1);
    wt(3);
    `CHK("en_b", 16'h0c0c, en)
    // sleep request on the third pin, low level
    i_host.set_pin(2, 0);
    wt(3);
    `CHK("slp", 16'h000c, slp)
    `CHK("en_kept", 16'h0c0c, en)
    `CHK("vsel_slp", 8'h82, vsel[2])
    i_host.set_pin(2, 1);
    wt(3);
    `CHK("wake", 16'h0000, slp)
    `CHK("vsel_nrm", 8'h12, vsel[2])
    // power-good source, only output one push-pull
    wt(1);
    `CHK("pg_lvl", 4'h5, lv[3:0])
    `CHK("pg_oe", 4'hb, oe[3:0])
    // register-bit source with driver types swapped
    src = 4'hf;
    rb = 4'ha;
    pp = 3'h6;
    wt(1);
    `CHK("rb_lvl", 4'ha, lv[3:0])
    `CHK("rb_oe", 4'h7, oe[3:0])
    // interrupt raised then cleared
    iset = 8'h04;
    wt(1);
    iset = 8'h00;
    wt(1);
    `CHK("irq_st", 8'h04, ist)
    `CHK("irq_pin", 1'b0, lv[4])
    iclr = 8'h04;
    wt(1);
    iclr = 8'h00;
    wt(2);
    `CHK("irq_clr", 8'h00, ist)
    `CHK("irq_rel", 1'b1, lv[4])
    // sixth pin as sleep request, then second pin falls
    sm_b = 1;
    sg_b = 16'h0c00;
    i_host.set_pin(5, 0);
    wt(3);
    `CHK("slp_b", 16'h0c00, slp)
    `CHK("en_b_kept", 16'h0c0c, en)
    `CHK("vsel_slp_b", 8'h8a, vsel[10])
    i_host.set_pin(1, 0);
    i_host.set_pin(5, 1);
    wt(3);
    `CHK("en_off_b", 16'h0c00, en)
    `CHK("wake_b", 16'h0000, slp)
    `CHK("vsel_nrm_b", 8'h1a, vsel[10])
    // set and clear in one cycle, set wins
    iset = 8'h01;
    iclr = 8'h01;
    wt(1);
    iset = 8'h00;
    iclr = 8'h00;
    `CHK("irq_set_wins", 8'h01, ist)
    summarize();
  end
endmodule : testbench
